/* hdl/mtx_pkg.sv */
package mtx_pkg;
    // --------------------------------------------------------------
    // interface mode and link speed selection
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        MTX_GMII  = 2'b00,
        MTX_RGMII = 2'b01,
        MTX_MII   = 2'b11,
        MTX_RVMII = 2'b10
    } mtx_mode_t;

    typedef enum logic [1:0] {
        MTX_SPD_10   = 2'b00,
        MTX_SPD_100  = 2'b01,
        MTX_SPD_1000 = 2'b10
    } mtx_speed_t;

    // --------------------------------------------------------------
    // timing: reference rate and scaled half periods of the link clock
    // --------------------------------------------------------------
    localparam int unsigned REF_CLK_HZ     = 10_000_000;
    localparam int unsigned HALF_CYC_1000  = 1;   // fastest rate the ref clock can make
    localparam int unsigned HALF_CYC_100   = 5;   // keeps 1000:100 ratio of 5
    localparam int unsigned HALF_CYC_10    = 50;  // keeps 100:10 ratio of 10
    localparam int unsigned HALF_CNT_W     = 8;

    // --------------------------------------------------------------
    // data layout
    // --------------------------------------------------------------
    localparam int unsigned BYTE_W   = 8;
    localparam int unsigned NIB_W    = 4;
    localparam logic [3:0]  NIB_ZERO = 4'h0;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
endpackage : mtx_pkg

/* hdl/mtx_edge_if.sv */
`timescale 1ns/1ps
// --------------------------------------------------------------
// edge events of the transmit link clock, from generator to launcher
// --------------------------------------------------------------
interface mtx_edge_if;
    logic tick_rise;    // link clock rises at this ref edge
    logic tick_fall;    // link clock falls at this ref edge
    modport gen (output tick_rise, output tick_fall);
    modport use_side (input tick_rise, input tick_fall);
endinterface : mtx_edge_if

/* hdl/mtx_clk_gen.sv */
`timescale 1ns/1ps
module mtx_clk_gen #(
    parameter int unsigned HALF_1000 = mtx_pkg::HALF_CYC_1000,
    parameter int unsigned HALF_100  = mtx_pkg::HALF_CYC_100,
    parameter int unsigned HALF_10   = mtx_pkg::HALF_CYC_10
) (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // configuration
    input  wire mtx_pkg::mtx_mode_t  mode,
    input  wire mtx_pkg::mtx_speed_t speed,
    // partner clock pin, asynchronous
    input  wire logic               ext_clk,
    // edge events
    mtx_edge_if.gen                 edges
);
    import mtx_pkg::*;

    logic [HALF_CNT_W-1:0] cnt;
    logic                  phase;
    logic                  sync_a;
    logic                  sync_b;
    logic                  sync_prev;
    logic [2:0]            fill;       // sync history filled after reset
    logic                  hist_ok;
    logic [HALF_CNT_W-1:0] half_last;
    logic                  wrap;
    logic                  ext_mode;

    // half period select per speed
    assign half_last = (speed == MTX_SPD_1000) ? HALF_CNT_W'(HALF_1000 - 1) :
                       (speed == MTX_SPD_100)  ? HALF_CNT_W'(HALF_100 - 1)  :
                                                 HALF_CNT_W'(HALF_10 - 1);
    assign wrap     = (cnt >= half_last);
    assign ext_mode = (mode == MTX_MII);

    // divider for device sourced clocks
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt   <= '0;
            phase <= 1'b0;
        end else if (ext_mode || wrap) begin
            cnt   <= '0;
            phase <= ext_mode ? 1'b0 : ~phase;
        end else begin
            cnt   <= cnt + HALF_CNT_W'(1);
        end
    end

    // two flop sync of partner clock, then edge history
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_a    <= 1'b0;
            sync_b    <= 1'b0;
            sync_prev <= 1'b0;
            fill      <= '0;
        end else begin
            sync_a    <= ext_clk;
            sync_b    <= sync_a;
            sync_prev <= sync_b;
            fill      <= {fill[1:0], 1'b1};
        end
    end

    // edge events from the selected source; partner edges wait until the
    // history has filled, so a pin already high at release makes no false rise
    assign hist_ok         = fill[2];
    assign edges.tick_rise = ext_mode ? (hist_ok & sync_b & ~sync_prev) : (wrap & ~phase);
    assign edges.tick_fall = ext_mode ? (hist_ok & ~sync_b & sync_prev) : (wrap & phase);
endmodule : mtx_clk_gen

/* hdl/mtx_top.sv */
`timescale 1ns/1ps
// Functional notes
// - reset returns all state to idle
// - GMII/RGMII device drives gigabit clock, speed rate
// - GMII launches eight bits on rising edge
// - RGMII gigabit: low nibble rise, high fall
// - RGMII 10/100: nibble on rising edge only
// - MII launches on partner clock rising edge
// - RvMII device drives MII clock pin out
// - RvMII nibble launched on driven clock rise
// - GMII/MII valid high while data valid
// - RGMII control: valid rise, xor error fall
// - error marks bad frame while valid high
module mtx_top #(
    parameter int unsigned HALF_1000 = mtx_pkg::HALF_CYC_1000,
    parameter int unsigned HALF_100  = mtx_pkg::HALF_CYC_100,
    parameter int unsigned HALF_10   = mtx_pkg::HALF_CYC_10
) (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    // configuration
    input  wire mtx_pkg::mtx_mode_t           mode,
    input  wire mtx_pkg::mtx_speed_t          speed,
    // byte source, same clock domain
    input  wire logic [mtx_pkg::BYTE_W-1:0]  src_data,
    input  wire logic                        src_valid,
    input  wire logic                        src_error,
    output logic                             src_ready,
    // management port pins
    output logic                             mgmt_gig_tx_clock,
    input  wire logic                        mgmt_mii_tx_clock_in,
    output logic                             mgmt_mii_tx_clock_out,
    output logic                             mgmt_mii_tx_clock_oe,
    output logic [mtx_pkg::BYTE_W-1:0]       mgmt_txd,
    output logic                             mgmt_tx_valid,
    output logic                             mgmt_tx_error
);
    import mtx_pkg::*;

    // --------------------------------------------------------------
    // decode helpers
    // --------------------------------------------------------------
    // the nibble clock pin turns into an output only in reverse mode
    function automatic logic mii_pin_driven(input mtx_mode_t m);
        return (m == MTX_RVMII);
    endfunction : mii_pin_driven

    // --------------------------------------------------------------
    // link clock edges
    // --------------------------------------------------------------
    // ticks mark the ref edges at which the link clock changes level
    mtx_edge_if edges ();

    // partner clock pin is only read in mii mode
    mtx_clk_gen #(
        .HALF_1000 (HALF_1000),
        .HALF_100  (HALF_100),
        .HALF_10   (HALF_10)
    ) u_gen (
        .ref_clk (ref_clk),
        .rst     (rst),
        .mode    (mode),
        .speed   (speed),
        .ext_clk (mgmt_mii_tx_clock_in),
        .edges   (edges.gen)
    );

    // --------------------------------------------------------------
    // mode decoding
    // --------------------------------------------------------------
    logic is_gmii;
    logic is_rgmii;
    logic gig_drv;
    logic rgmii_ddr;
    logic byte_wide;
    logic rise;
    logic fall;

    // mode and speed are static: change them only while in reset
    // rgmii at gigabit is the only double data rate case
    assign is_gmii   = (mode == MTX_GMII);
    assign is_rgmii  = (mode == MTX_RGMII);
    assign gig_drv   = is_gmii | is_rgmii;
    assign rgmii_ddr = is_rgmii & (speed == MTX_SPD_1000);
    assign byte_wide = is_gmii | rgmii_ddr;                       // whole byte per rise
    assign rise      = edges.tick_rise;
    assign fall      = edges.tick_fall;

    // --------------------------------------------------------------
    // launch state
    // --------------------------------------------------------------
    // held byte and nibble phase move only at a link rise
    logic [BYTE_W-1:0] held;      // byte being sent
    logic              held_err;
    logic              hi_next;   // high nibble owed at next rise
    logic              active;    // frame data on the lines

    logic              take;
    logic              next_active;
    logic [BYTE_W-1:0] next_txd;
    logic              next_valid;
    logic              next_error;

    // a new byte is taken on a rise unless a high nibble is still owed;
    // the source holds byte and valid until src_ready, so a byte offered
    // while a high nibble is owed just waits for the following rise
    assign take = rise & ~hi_next & src_valid;

    // rising edge data: whole byte, low nibble, or owed high nibble
    assign next_txd =
        byte_wide ? (rgmii_ddr ? {NIB_ZERO, src_data[NIB_W-1:0]}
                               : src_data)
                  : (hi_next ? {NIB_ZERO, held[BYTE_W-1:NIB_W]}
                             : {NIB_ZERO, src_data[NIB_W-1:0]});
    // valid and error hold for both nibbles of a byte
    assign next_active = hi_next | take;
    assign next_valid  = next_active;
    assign next_error  = hi_next ? held_err : (take & src_error);

    // byte capture and nibble phase
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            held     <= BYTE_ZERO;
            held_err <= 1'b0;
            hi_next  <= 1'b0;
            active   <= 1'b0;
        end else if (rise) begin
            held     <= take ? src_data : held;
            held_err <= take ? src_error : held_err;
            hi_next  <= take & ~byte_wide;                          // nibble modes owe high half
            active   <= next_active;
        end
    end

    // source handshake pulse, one cycle after the byte is taken
    // the source may offer its next byte in the cycle after the pulse
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            src_ready <= 1'b0;
        end else begin
            src_ready <= take;
        end
    end

    // --------------------------------------------------------------
    // pin values at each kind of link edge
    // --------------------------------------------------------------
    logic [BYTE_W-1:0] rise_txd;
    logic              rise_error;
    logic [BYTE_W-1:0] fall_txd;
    logic              fall_valid;
    logic              held_err_f;    // error of the byte on the lines

    // lines idle at zero between frames so no stale byte is seen
    assign rise_txd   = next_active ? next_txd : BYTE_ZERO;
    // the error pin stays low in rgmii, where the control line carries it
    assign rise_error = is_rgmii ? 1'b0 : (next_active & next_error);
    // high nibble of the byte on the lines, for the gigabit rgmii fall
    assign fall_txd   = active ? {NIB_ZERO, held[BYTE_W-1:NIB_W]} : BYTE_ZERO;
    // falling control is enable xor error of the byte on the lines
    assign held_err_f = active & held_err;
    assign fall_valid = active ^ held_err_f;

    // data and control pins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mgmt_txd      <= BYTE_ZERO;
            mgmt_tx_valid <= 1'b0;
            mgmt_tx_error <= 1'b0;
        end else if (rise) begin
            mgmt_txd      <= rise_txd;
            mgmt_tx_valid <= next_valid;
            mgmt_tx_error <= rise_error;
        end else if (fall && is_rgmii) begin
            mgmt_tx_valid <= fall_valid;
            if (rgmii_ddr) begin
                mgmt_txd <= fall_txd;
            end
        end
    end

    // --------------------------------------------------------------
    // transmit clock pins
    // --------------------------------------------------------------
    // gigabit clock follows the divider in GMII and RGMII, low otherwise
    // clock and data flops share a ref edge, so they leave together
    // an unused pin stays low and quiet
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mgmt_gig_tx_clock <= 1'b0;
        end else if (!gig_drv) begin
            mgmt_gig_tx_clock <= 1'b0;
        end else if (rise) begin
            mgmt_gig_tx_clock <= 1'b1;
        end else if (fall) begin
            mgmt_gig_tx_clock <= 1'b0;
        end
    end

    // MII clock pin is driven only in RvMII, an input in MII
    // in mii the partner drives the pin, so the output stays off
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mgmt_mii_tx_clock_out <= 1'b0;
            mgmt_mii_tx_clock_oe  <= 1'b0;
        end else begin
            mgmt_mii_tx_clock_oe  <= mii_pin_driven(mode);
            if (!mii_pin_driven(mode)) begin
                mgmt_mii_tx_clock_out <= 1'b0;
            end else if (rise) begin
                mgmt_mii_tx_clock_out <= 1'b1;
            end else if (fall) begin
                mgmt_mii_tx_clock_out <= 1'b0;
            end
        end
    end
endmodule : mtx_top

/* dv/mtx_chk.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// protocol checker for the management transmit port
// ----------------------------------------------------------------
module mtx_chk
    import mtx_pkg::*;
#(
    parameter int unsigned HALF_1000 = HALF_CYC_1000,
    parameter int unsigned HALF_100  = HALF_CYC_100,
    parameter int unsigned HALF_10   = HALF_CYC_10
) (
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst,
    // configuration
    input wire mtx_pkg::mtx_mode_t   mode,
    input wire mtx_pkg::mtx_speed_t  speed,
    // observed outputs
    input wire logic                 src_ready,
    input wire logic                 mgmt_gig_tx_clock,
    input wire logic                 mgmt_mii_tx_clock_out,
    input wire logic                 mgmt_mii_tx_clock_oe,
    input wire logic [BYTE_W-1:0]    mgmt_txd,
    input wire logic                 mgmt_tx_valid,
    input wire logic                 mgmt_tx_error
);
    logic       gig_mode;
    logic       lclk;
    logic [7:0] half;
    logic [7:0] hi_cnt;

    // link clock that the device drives, and its expected half period
    assign gig_mode = (mode == MTX_GMII) || (mode == MTX_RGMII);
    assign lclk     = gig_mode ? mgmt_gig_tx_clock : mgmt_mii_tx_clock_out;
    assign half     = (speed == MTX_SPD_1000) ? 8'(HALF_1000) :
                      (speed == MTX_SPD_100) ? 8'(HALF_100) : 8'(HALF_10);

    // counts ref cycles the link clock has stayed high
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) hi_cnt <= 8'h00;
        else hi_cnt <= lclk ? hi_cnt + 8'h01 : 8'h00;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_RST_IDLE: assert property (disable iff (1'b0) rst |-> !mgmt_tx_valid &&
        mgmt_txd == 8'h00 && !src_ready) else $error("output active in reset");
    AST_HALF_PERIOD: assert property (mode != MTX_MII && $fell(lclk)
        |-> hi_cnt == half) else $error("link clock half period wrong");
    AST_GIG_IDLE: assert property (!gig_mode |-> !mgmt_gig_tx_clock)
        else $error("gigabit clock runs outside gmii or rgmii");
    AST_OE_MODE: assert property (!$past(rst) && !$past(rst, 2)
        |-> mgmt_mii_tx_clock_oe == (mode == MTX_RVMII)) else $error("clock pin drive wrong");
    AST_DATA_ON_RISE: assert property (mode != MTX_MII &&
        !(mode == MTX_RGMII && speed == MTX_SPD_1000) && $changed(mgmt_txd)
        |-> $rose(lclk)) else $error("data changed off the rising edge");
    AST_IDLE_ZERO: assert property (mode != MTX_RGMII && !mgmt_tx_valid
        |-> mgmt_txd == 8'h00) else $error("data lines busy while not valid");
    AST_ERR_IN_FRAME: assert property (mgmt_tx_error |-> mgmt_tx_valid)
        else $error("error raised outside frame");
    AST_RGMII_NO_ERR: assert property (mode == MTX_RGMII |-> !mgmt_tx_error)
        else $error("error pin used in rgmii");
    AST_TAKE_ON_RISE: assert property (src_ready && mode != MTX_MII
        |-> $rose(lclk)) else $error("byte taken off a link rise");
    AST_NIB_HIGH: assert property (mode != MTX_GMII |-> mgmt_txd[7:4] == 4'h0)
        else $error("upper lines used in nibble mode");
endmodule : mtx_chk

bind mtx_top mtx_chk #(
    .HALF_1000 (HALF_1000),
    .HALF_100  (HALF_100),
    .HALF_10   (HALF_10)
) u_chk (
    .ref_clk               (ref_clk),
    .rst                   (rst),
    .mode                  (mode),
    .speed                 (speed),
    .src_ready             (src_ready),
    .mgmt_gig_tx_clock     (mgmt_gig_tx_clock),
    .mgmt_mii_tx_clock_out (mgmt_mii_tx_clock_out),
    .mgmt_mii_tx_clock_oe  (mgmt_mii_tx_clock_oe),
    .mgmt_txd              (mgmt_txd),
    .mgmt_tx_valid         (mgmt_tx_valid),
    .mgmt_tx_error         (mgmt_tx_error)
);

/* dv/mtx_partner.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far-end management entity receiving the transmit stream
// ----------------------------------------------------------------
module mtx_partner
    import mtx_pkg::*;
(
    // configuration straps
    input wire mtx_pkg::mtx_mode_t   mode,
    input wire mtx_pkg::mtx_speed_t  speed,
    input wire logic                 run,
    // management port pins
    input wire logic                 gig_clk,
    input wire logic                 pin_clk,
    input wire logic [7:0]           txd,
    input wire logic                 tv,
    input wire logic                 te,
    output logic                     own_clk
);
    logic [8:0] got[$];
    logic [3:0] lo;
    logic       hf = 1'b0;
    logic       vr = 1'b0;
    logic       ee = 1'b0;
    wire        lk = (mode == MTX_GMII || mode == MTX_RGMII) ? gig_clk : pin_clk;

    // own transmit clock, 800 ns period, still unless a run is on
    initial own_clk = 1'b0;
    always #400 if (run) own_clk = ~own_clk;

    // take a byte or a nibble just after each link rise
    always @(posedge lk) begin
        #1;
        vr = tv;
        if (mode == MTX_RGMII && speed == MTX_SPD_1000) lo = txd[3:0];
        else if (mode == MTX_GMII) begin
            if (tv) got.push_back({te, txd});
        end else if (!tv) hf = 1'b0;
        else if (!hf) begin
            lo = txd[3:0];
            hf = 1'b1;
        end else begin
            got.push_back({te | ee, txd[3:0], lo});
            hf = 1'b0;
        end
    end

    // falling control carries valid xor error in rgmii
    always @(negedge lk) begin
        #1;
        if (mode == MTX_RGMII && vr) begin
            ee = !tv;
            if (speed == MTX_SPD_1000) got.push_back({ee, txd[3:0], lo});
        end
    end
endmodule : mtx_partner

/* dv/mtx_top_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ----------------------------------------------------------------
// self-checking bench of the management transmit port
// ----------------------------------------------------------------
module mtx_top_bench;
    import mtx_pkg::*;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b0;    // first start raises it, so the async reset sees an edge
    mtx_mode_t  mode = MTX_GMII;
    mtx_speed_t speed = MTX_SPD_1000;
    logic [7:0] src_data = 8'h00;
    logic       src_valid = 1'b0;
    logic       src_error = 1'b0;
    logic       mii_run = 1'b0;
    logic       ready, gig, ck_out, ck_oe, tv, te, own_clk;
    logic [7:0] txd;
    wire        pin = ck_oe ? ck_out : own_clk;
    logic [8:0] exp_b [3] = '{9'h0a5, 9'h13c, 9'h0f0};
    int         num_errors = 0;
    int         checked = 0;

    // 10 MHz reference, supplied without a break
    always #50 ref_clk = ~ref_clk;

    mtx_top dut (.ref_clk(ref_clk), .rst(rst), .mode(mode), .speed(speed),
        .src_data(src_data), .src_valid(src_valid), .src_error(src_error),
        .src_ready(ready), .mgmt_gig_tx_clock(gig), .mgmt_mii_tx_clock_in(pin),
        .mgmt_mii_tx_clock_out(ck_out), .mgmt_mii_tx_clock_oe(ck_oe),
        .mgmt_txd(txd), .mgmt_tx_valid(tv), .mgmt_tx_error(te));
    mtx_partner far (.mode(mode), .speed(speed), .run(mii_run), .gig_clk(gig),
        .pin_clk(pin), .txd(txd), .tv(tv), .te(te), .own_clk(own_clk));

    task automatic start(input mtx_mode_t m, input mtx_speed_t s);
        rst <= 1'b1;
        mode <= m;
        speed <= s;
        mii_run <= (m == MTX_MII);
        repeat (20) @(posedge ref_clk);
        far.got.delete();
        far.hf = 1'b0;
        far.ee = 1'b0;
        rst <= 1'b0;
        @(posedge ref_clk);
    endtask : start

    task automatic put(input logic [7:0] d, input logic e);
        int n;
        n = 0;
        src_data <= d;
        src_valid <= 1'b1;
        src_error <= e;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ready !== 1'b1 && n < 3000);
        `CHK(ready, 1'b1)
    endtask : put

    task automatic run(input mtx_mode_t m, input mtx_speed_t s, input string name);
        int n;
        n = 0;
        start(m, s);
        for (int i = 0; i < 3; i++) put(exp_b[i][7:0], exp_b[i][8]);
        src_valid <= 1'b0;
        src_error <= 1'b0;
        while (far.got.size() < 3 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(far.got.size(), 3)
        for (int i = 0; i < far.got.size() && i < 3; i++) begin
            `CHK(far.got[i], exp_b[i])
        end
        $display("%s done", name);
    endtask : run

    task automatic t_gmii;
        run(MTX_GMII, MTX_SPD_1000, "gmii 1000");
        run(MTX_GMII, MTX_SPD_10, "gmii 10");
    endtask : t_gmii

    task automatic t_rgmii;
        run(MTX_RGMII, MTX_SPD_1000, "rgmii 1000");
        run(MTX_RGMII, MTX_SPD_100, "rgmii 100");
    endtask : t_rgmii

    task automatic t_mii_rvmii;
        run(MTX_MII, MTX_SPD_100, "mii 100");
        run(MTX_RVMII, MTX_SPD_10, "rvmii 10");
    endtask : t_mii_rvmii

    task automatic t_reset;
        start(MTX_GMII, MTX_SPD_100);
        put(8'h5a, 1'b1);
        rst <= 1'b1;
        src_valid <= 1'b0;
        #1;
        `CHK({tv, te, txd, gig}, 11'h000)
        @(posedge ref_clk);
        $display("reset in frame done");
    endtask : t_reset

    task automatic conclude;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude

    // watchdog against a hung handshake
    initial begin
        #4000000;
        num_errors++;
        conclude();
    end

    // main sequence
    initial begin
        t_gmii();
        t_rgmii();
        t_mii_rvmii();
        t_reset();
        conclude();
    end
endmodule : mtx_top_bench
